// ### common/csp_map.vh
// Constants for the context image and per-process status page writer.
// Assumes dword addressing; byte address is dword index times four.
`ifndef CSP_MAP_VH
`define CSP_MAP_VH

// Status page dword offsets
`define CSP_SP_HEAD_DW      10'h004
`define CSP_SP_FAULT_LO_DW  10'h010
`define CSP_SP_FAULT_HI_DW  10'h011
`define CSP_SP_TS_SWITCH_DW 10'h018
`define CSP_SP_TS_PREEMPT_DW 10'h019
`define CSP_SP_TS_RESTORE_DW 10'h01A
`define CSP_SP_TS_SAVE_DW   10'h01B
`define CSP_SP_GP_FIRST_DW  10'h020
`define CSP_SP_GP_LAST_DW   10'h3FF

// Context image pages (4K each)
`define CSP_PAGE_BYTES      13'h1000
`define CSP_PAGES_PPT       4'hB
`define CSP_PG_REGSTATE     4'h0
`define CSP_PG_PROBE        4'h1
`define CSP_PG_PIPE0        4'h2
`define CSP_PG_RING0        4'h6
`define CSP_PG_STATUS       4'hA

// Register/state context dwords
`define CSP_RS_HEAD_DW      10'h001
`define CSP_RS_TAIL_DW      10'h002
`define CSP_RS_DIRBASE_DW   10'h007

// Register/state cache lines
`define CSP_LINE_RING       6'h00
`define CSP_LINE_PROBE_LO   6'h01
`define CSP_LINE_PROBE_HI   6'h02
`define CSP_LINE_3D_LO      6'h03
`define CSP_LINE_3D_HI      6'h0A
`define CSP_LINE_MEDIA_LO   6'h0B
`define CSP_LINE_MEDIA_HI   6'h0D
`define CSP_LINE_PAL_LO     6'h10
`define CSP_LINE_PAL_HI     6'h30

// Memory attribute: cacheable, snooped
`define CSP_ATTR_SNOOP      2'h3

`endif

// ### core/csp_cl_class.v
// Classifies a register/state context cache line index into its region.
// Assumes the index is the cache line within the register/state page.
`timescale 1ns/1ps
`include "csp_map.vh"

module csp_line_class (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_sys_rst,
  // Cache line in
  input  wire [5:0] i_cache_line_index,
  // Region code out: 0 ring,1 probe,2 3D,3 media,4 palette,7 other
  output reg  [2:0] o_region
);

  reg [2:0] region_nxt;

  always @* begin
    region_nxt = 3'h7;
    if (i_cache_line_index == `CSP_LINE_RING)
      region_nxt = 3'h0;
    else if (i_cache_line_index >= `CSP_LINE_PROBE_LO && i_cache_line_index <= `CSP_LINE_PROBE_HI)
      region_nxt = 3'h1;
    else if (i_cache_line_index >= `CSP_LINE_3D_LO && i_cache_line_index <= `CSP_LINE_3D_HI)
      region_nxt = 3'h2;
    else if (i_cache_line_index >= `CSP_LINE_MEDIA_LO && i_cache_line_index <= `CSP_LINE_MEDIA_HI)
      region_nxt = 3'h3;
    else if (i_cache_line_index >= `CSP_LINE_PAL_LO && i_cache_line_index <= `CSP_LINE_PAL_HI)
      region_nxt = 3'h4;
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_region <= 3'h7;
    end else begin
      o_region <= region_nxt;
    end
  end

endmodule // csp_line_class

// ### core/csp_status_writer.v
// Status page and context image writer of the rendering engine.
// Assumes memory accepts one dword write per cycle when o_wr_valid & i_wr_ready.
`timescale 1ns/1ps
`include "csp_map.vh"

module csp_status_writer #(
  parameter AW = 32,
  parameter DW = 32
) (
  // Clock and reset
  input  wire          i_clk,
  input  wire          i_sys_rst,
  // Configuration
  input  wire [AW-1:0] i_image_base,
  input  wire          i_per_process_translation,
  input  wire          i_restore_inhibit,
  // Events
  input  wire          i_report_head_command,
  input  wire          i_auto_head_report,
  input  wire [DW-1:0] i_ring_head,
  input  wire          i_ev_switch,
  input  wire          i_ev_preempt,
  input  wire          i_ev_restore_done,
  input  wire          i_ev_save_done,
  input  wire [DW-1:0] i_timestamp,
  input  wire          i_probe_fault,
  input  wire [63:0]   i_probe_fault_val,
  // Store commands (dword offset into status page)
  input  wire          i_store_valid,
  input  wire [9:0]    i_store_dw,
  input  wire [DW-1:0] i_store_data,
  // Save and restore queries
  input  wire [9:0]    i_rs_dw,
  input  wire          i_ring_reissue,
  input  wire [5:0]    i_cache_line_index,
  // Memory write port
  input  wire          i_wr_ready,
  output reg           o_wr_valid,
  output reg  [AW-1:0] o_wr_addr,
  output reg  [DW-1:0] o_wr_data,
  output reg  [1:0]    o_wr_attr,
  // Layout and status
  output reg           o_store_ready,
  output reg           o_store_reject,
  output reg  [AW-1:0] o_pipe_base,
  output reg  [AW-1:0] o_ring_scratch_base,
  output reg  [3:0]    o_image_pages,
  output reg           o_dw_save_en,
  output reg           o_dw_restore_en,
  output reg  [2:0]    o_line_region
);

  // ***************************************************
  // Pending events
  // ***************************************************
  localparam NEV = 8;
  // Bits: 0 head,1 switch,2 preempt,3 restore,4 save,5 fault lo,6 fault hi,7 store
  reg  [NEV-1:0] pend_r;
  reg  [DW-1:0]  val_r [0:NEV-1];
  reg  [9:0]     sdw_r;
  wire [NEV-1:0] ev_in;
  wire [DW-1:0]  ev_val [0:NEV-1];
  wire           store_ok;

  assign store_ok = i_store_valid && i_store_dw >= `CSP_SP_GP_FIRST_DW
                    && i_store_dw <= `CSP_SP_GP_LAST_DW && !pend_r[7];

  assign ev_in[0]  = i_report_head_command | i_auto_head_report;
  assign ev_in[1]  = i_ev_switch;
  assign ev_in[2]  = i_ev_preempt;
  assign ev_in[3]  = i_ev_restore_done;
  assign ev_in[4]  = i_ev_save_done;
  assign ev_in[5]  = i_probe_fault;
  assign ev_in[6]  = i_probe_fault;
  assign ev_in[7]  = store_ok;
  assign ev_val[0] = i_ring_head;
  assign ev_val[1] = i_timestamp;
  assign ev_val[2] = i_timestamp;
  assign ev_val[3] = i_timestamp;
  assign ev_val[4] = i_timestamp;
  assign ev_val[5] = i_probe_fault_val[31:0];
  assign ev_val[6] = i_probe_fault_val[63:32];
  assign ev_val[7] = i_store_data;

  // ***************************************************
  // Arbitration
  // ***************************************************
  reg [2:0] sel;
  reg       any;
  integer   k;
  always @* begin
    sel = 3'h0;
    any = 1'b0;
    for (k = NEV - 1; k >= 0; k = k - 1) begin
      if (pend_r[k]) begin
        sel = k[2:0];
        any = 1'b1;
      end
    end
  end

  reg [9:0] sel_dw;
  always @* begin
    case (sel)
      3'h0: sel_dw = `CSP_SP_HEAD_DW;
      3'h1: sel_dw = `CSP_SP_TS_SWITCH_DW;
      3'h2: sel_dw = `CSP_SP_TS_PREEMPT_DW;
      3'h3: sel_dw = `CSP_SP_TS_RESTORE_DW;
      3'h4: sel_dw = `CSP_SP_TS_SAVE_DW;
      3'h5: sel_dw = `CSP_SP_FAULT_LO_DW;
      3'h6: sel_dw = `CSP_SP_FAULT_HI_DW;
      default: sel_dw = sdw_r;
    endcase
  end

  wire issue = any && (!o_wr_valid || i_wr_ready);

  // ***************************************************
  // Layout
  // ***************************************************
  wire [AW-1:0] page_sz = {{(AW-13){1'b0}}, `CSP_PAGE_BYTES};
  wire [AW-1:0] status_base;
  // status page is last of eleven
  assign status_base = i_per_process_translation ?
                       i_image_base + page_sz * `CSP_PG_STATUS : i_image_base;

  genvar g;
  generate
    for (g = 0; g < NEV; g = g + 1) begin : g_ev
      // Set wins over the clear of the same cycle
      always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          pend_r[g] <= 1'b0;
          val_r[g]  <= {DW{1'b0}};
        end else if (ev_in[g]) begin
          pend_r[g] <= 1'b1;
          val_r[g]  <= ev_val[g];
        end else if (issue && sel == g) begin
          pend_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sdw_r <= 10'h000;
    end else if (store_ok) begin
      sdw_r <= i_store_dw;
    end
  end

  // ***************************************************
  // Write port
  // ***************************************************
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wr_valid <= 1'b0;
      o_wr_addr  <= {AW{1'b0}};
      o_wr_data  <= {DW{1'b0}};
      o_wr_attr  <= `CSP_ATTR_SNOOP;
    end else if (issue) begin
      o_wr_valid <= 1'b1;
      o_wr_addr  <= status_base + {{(AW-12){1'b0}}, sel_dw, 2'b00};
      o_wr_data  <= val_r[sel];
      o_wr_attr  <= `CSP_ATTR_SNOOP;
    end else if (i_wr_ready) begin
      o_wr_valid <= 1'b0;
    end
  end

  // ***************************************************
  // Save and restore policy
  // ***************************************************
  wire tail_or_dir = (i_rs_dw == `CSP_RS_TAIL_DW) || (i_rs_dw == `CSP_RS_DIRBASE_DW);
  wire head_dw    = (i_rs_dw == `CSP_RS_HEAD_DW);
  wire [2:0] region;

  csp_line_class u_line (
    .i_clk              (i_clk),
    .i_sys_rst          (i_sys_rst),
    .i_cache_line_index (i_cache_line_index),
    .o_region           (region)
  );

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_store_ready       <= 1'b0;
      o_store_reject      <= 1'b0;
      o_pipe_base         <= {AW{1'b0}};
      o_ring_scratch_base <= {AW{1'b0}};
      o_image_pages       <= 4'h1;
      o_dw_save_en        <= 1'b0;
      o_dw_restore_en     <= 1'b0;
      o_line_region       <= 3'h7;
    end else begin
      o_store_ready  <= !pend_r[7];
      o_store_reject <= i_store_valid && !store_ok;
      o_line_region  <= region;
      o_image_pages  <= i_per_process_translation ? `CSP_PAGES_PPT : 4'h1;
      o_pipe_base    <= i_per_process_translation ?
                        i_image_base + page_sz * `CSP_PG_PIPE0 : i_image_base;
      o_ring_scratch_base <= (i_per_process_translation && i_ring_reissue) ?
                             i_image_base + page_sz * `CSP_PG_RING0 : {AW{1'b0}};
      // Page_directory_base restore only; tail restore only
      o_dw_save_en    <= i_per_process_translation && head_dw;
      o_dw_restore_en <= i_per_process_translation &&
                         (tail_or_dir || (head_dw && !i_restore_inhibit));
    end
  end

endmodule // csp_status_writer

// ### tb/csp_monitor.sv
// Port checker for the status page writer.
// Assumes it is bound to csp_status_writer and sees its ports only.
`timescale 1ns/1ps
module csp_monitor #(
  parameter AW = 32,
  parameter DW = 32
) (
  input wire          i_clk,
  input wire          i_sys_rst,
  input wire [AW-1:0] i_image_base,
  input wire          i_per_process_translation,
  input wire          i_report_head_command,
  input wire          i_auto_head_report,
  input wire          i_ring_reissue,
  input wire [DW-1:0] i_ring_head,
  input wire          i_store_valid,
  input wire [9:0]    i_store_dw, i_rs_dw,
  input wire [5:0]    i_cache_line_index,
  input wire          i_wr_ready, o_wr_valid, o_store_reject, o_dw_save_en, o_dw_restore_en,
  input wire [AW-1:0] o_wr_addr, o_pipe_base, o_ring_scratch_base,
  input wire [DW-1:0] o_wr_data,
  input wire [1:0]    o_wr_attr,
  input wire [3:0]    o_image_pages,
  input wire [2:0]    o_line_region
);
  // ****************************************
  // Port relations
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_attr_snooped: assert property (o_wr_attr == 2'h3)
    else $error("write not cacheable snooped");
  a_request_held: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid
    && $stable(o_wr_addr) && $stable(o_wr_data)) else $error("write request dropped");
  a_head_report: assert property ((i_report_head_command || i_auto_head_report)
    && !o_wr_valid && i_wr_ready ##1 !i_report_head_command && !i_auto_head_report && i_wr_ready
    |=> o_wr_valid && o_wr_data == $past(i_ring_head, 2) && o_wr_addr == $past(i_image_base)
    + ($past(i_per_process_translation) ? 32'hA010 : 32'h10)) else $error("head report wrong");
  a_page_count: assert property (!$past(i_sys_rst) |-> o_image_pages ==
    ($past(i_per_process_translation) ? 4'hB : 4'h1)) else $error("image page count wrong");
  a_pipe_page: assert property (!$past(i_sys_rst) && $past(i_per_process_translation) |->
    o_pipe_base == $past(i_image_base) + 32'h2000
    && o_ring_scratch_base == ($past(i_ring_reissue) ? $past(i_image_base) + 32'h6000 : 32'h0))
    else $error("page base wrong");
  a_restore_only: assert property (!$past(i_sys_rst) && $past(i_per_process_translation)
    && ($past(i_rs_dw) == 10'h002 || $past(i_rs_dw) == 10'h007) |-> o_dw_restore_en
    && !o_dw_save_en) else $error("tail or directory base saved");
  a_store_reject: assert property (i_store_valid && i_store_dw < 10'h020 |=> o_store_reject)
    else $error("low store not refused");
  a_line_3d_region: assert property (i_cache_line_index >= 6'h03
    && i_cache_line_index <= 6'h0A |-> ##2 o_line_region == 3'h2)
    else $error("3D region code wrong");
endmodule // csp_monitor

bind csp_status_writer csp_monitor #(.AW(AW), .DW(DW)) mon_u (.i_clk, .i_sys_rst, .i_image_base,
  .i_per_process_translation, .i_report_head_command, .i_auto_head_report, .i_ring_reissue,
  .i_ring_head, .i_store_valid, .i_store_dw,
  .i_rs_dw, .i_cache_line_index, .i_wr_ready, .o_wr_valid, .o_store_reject, .o_dw_save_en,
  .o_dw_restore_en, .o_wr_addr, .o_pipe_base, .o_ring_scratch_base, .o_wr_data, .o_wr_attr,
  .o_image_pages, .o_line_region);

// ### tb/csp_mem_model.sv
// System memory stand-in for the context image; takes one dword per cycle and reports the last one taken.
// Assumes the bench stalls it through i_stall, changed at clock edges.
`timescale 1ns/1ps
module csp_mem_model (
  input  wire        i_clk, i_sys_rst, i_stall, i_valid,
  input  wire [31:0] i_addr, i_data,
  output wire        o_ready,
  output reg         o_acc,
  output reg  [31:0] o_acc_addr, o_acc_data
);
  assign o_ready = !i_stall;
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_acc <= 1'b0;
    end else begin
      o_acc <= i_valid && o_ready;
      if (i_valid && o_ready) begin
        o_acc_addr <= i_addr;
        o_acc_data <= i_data;
      end
    end
  end
endmodule // csp_mem_model

// ### tb/test_csp_status_writer.sv
// Bench for the status page writer, with a memory model on the write port.
// Assumes default widths of 32 bits.
`timescale 1ns/1ps
module test_csp_status_writer;
  reg         i_clk, i_sys_rst, i_per_process_translation, i_restore_inhibit, stall;
  reg         i_ring_reissue;
  wire        store_ready;
  reg  [31:0] i_image_base, val;
  reg  [9:0]  i_store_dw, i_rs_dw;
  reg  [5:0]  i_cache_line_index;
  reg  [7:0]  ev;
  wire        i_wr_ready, o_wr_valid, o_store_reject, o_dw_save_en, o_dw_restore_en, acc;
  wire [31:0] o_wr_addr, o_wr_data, o_pipe_base, o_ring_scratch_base, acc_addr, acc_data;
  wire [1:0]  o_wr_attr;
  wire [3:0]  o_image_pages;
  wire [2:0]  o_line_region;
  integer     num_errors, checks_done, k;

  csp_status_writer dut_u (.i_clk, .i_sys_rst, .i_image_base, .i_per_process_translation,
    .i_restore_inhibit, .i_report_head_command(ev[0]), .i_auto_head_report(ev[1]),
    .i_ring_head(val), .i_ev_switch(ev[2]), .i_ev_preempt(ev[3]), .i_ev_restore_done(ev[4]),
    .i_ev_save_done(ev[5]), .i_timestamp(val), .i_probe_fault(ev[6]),
    .i_probe_fault_val({~val, val}), .i_store_valid(ev[7]), .i_store_dw, .i_store_data(val),
    .i_rs_dw, .i_ring_reissue, .i_cache_line_index, .i_wr_ready,
    .o_wr_valid, .o_wr_addr, .o_wr_data, .o_wr_attr, .o_store_ready(store_ready),
    .o_store_reject, .o_pipe_base, .o_ring_scratch_base, .o_image_pages, .o_dw_save_en,
    .o_dw_restore_en, .o_line_region);
  csp_mem_model mem_u (.i_clk, .i_sys_rst, .i_stall(stall), .i_valid(o_wr_valid),
    .i_addr(o_wr_addr), .i_data(o_wr_data), .o_ready(i_wr_ready), .o_acc(acc),
    .o_acc_addr(acc_addr), .o_acc_data(acc_data));

  always #2.5 i_clk = ~i_clk;

  // ****************************************
  // Tasks
  // ****************************************
  task print_verdict;
    begin
      if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task fire(input integer b, input [31:0] v);
    begin
      @(posedge i_clk) begin ev <= 8'h01 << b; val <= v; end
      @(posedge i_clk) ev <= 8'h00;
    end
  endtask
  task wait_wr(input [31:0] a, input [31:0] d);
    integer n;
    begin
      for (n = 0; n < 40; n = n + 1) begin
        @(posedge i_clk);
        #1;
        if (acc === 1'b1) n = 99;
      end
      if (n != 100) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: write never accepted", $time);
        print_verdict;
      end else begin
        check(acc_addr, a);
        check(acc_data, d);
      end
    end
  endtask
  function [2:0] region(input [5:0] c);
    region = (c == 6'h00) ? 3'h0 : (c <= 6'h02) ? 3'h1 : (c <= 6'h0A) ? 3'h2 :
             (c <= 6'h0D) ? 3'h3 : (c >= 6'h10 && c <= 6'h30) ? 3'h4 : 3'h7;
  endfunction

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    i_clk = 0; i_sys_rst = 1; i_per_process_translation = 0; i_restore_inhibit = 0;
    stall = 0; i_image_base = 32'h0010_0000; val = 0; i_store_dw = 0; i_rs_dw = 0;
    i_cache_line_index = 0; ev = 0; num_errors = 0; checks_done = 0;
    i_ring_reissue = 1;
    @(posedge i_clk);
    #1;
    check(o_image_pages, 4'h1);
    check(o_line_region, 3'h7);
    @(posedge i_clk) i_sys_rst <= 1'b0;
    fire(0, 32'h0000_1234);
    wait_wr(32'h0010_0010, 32'h0000_1234);
    @(posedge i_clk) i_per_process_translation <= 1'b1;
    fire(1, 32'h0000_5678);
    wait_wr(32'h0010_A010, 32'h0000_5678);
    @(posedge i_clk) stall <= 1'b1;
    for (k = 0; k < 4; k = k + 1) fire(2 + k, 32'h0000_00A0 + k);
    @(posedge i_clk) stall <= 1'b0;
    for (k = 0; k < 4; k = k + 1) wait_wr(32'h0010_A060 + 4 * k, 32'h0000_00A0 + k);
    fire(6, 32'h0000_00C5);
    wait_wr(32'h0010_A040, 32'h0000_00C5);
    wait_wr(32'h0010_A044, 32'hFFFF_FF3A);
    check(store_ready, 1'b1);
    @(posedge i_clk) i_store_dw <= 10'h3FF;
    fire(7, 32'h0000_BEEF);
    @(posedge i_clk);
    #1;
    check(store_ready, 1'b0);
    wait_wr(32'h0010_AFFC, 32'h0000_BEEF);
    @(posedge i_clk) i_store_dw <= 10'h01F;
    fire(7, 32'h0000_0BAD);
    #1;
    check(o_store_reject, 1'b1);
    check(o_image_pages, 4'hB);
    check(o_pipe_base, 32'h0010_2000);
    check(o_ring_scratch_base, 32'h0010_6000);
    for (k = 0; k < 3; k = k + 1) begin
      @(posedge i_clk) begin
        i_restore_inhibit <= 1'b1;
        i_ring_reissue <= 1'b0;
        i_rs_dw <= (k == 0) ? 10'h002 : (k == 1) ? 10'h007 : 10'h001;
      end
      @(posedge i_clk);
      #1;
      check(o_dw_restore_en, k < 2);
      check(o_dw_save_en, k == 2);
    end
    check(o_ring_scratch_base, 32'h0000_0000);
    @(posedge i_clk) i_per_process_translation <= 1'b0;
    @(posedge i_clk);
    #1;
    check(o_image_pages, 4'h1);
    check(o_pipe_base, 32'h0010_0000);
    for (k = 0; k < 64; k = k + 1) begin
      @(posedge i_clk) i_cache_line_index <= k[5:0];
      repeat (2) @(posedge i_clk);
      #1;
      check(o_line_region, region(k));
    end
    print_verdict;
  end
endmodule // test_csp_status_writer
